//--- servo_supervisor_params.svh
/*
  Constants for the servo supervisory block: setting ranges, reset values,
  encodings, control-port offsets and timing counts.
  Assumes a 10 MHz clock MCLK; included by the top module only.
*/
`ifndef SERVO_SUPERVISOR_PARAMS_SVH
`define SERVO_SUPERVISOR_PARAMS_SVH

// Clock and time base
`define CLK_HZ            10000000
`define MS_TIME           1
`define CYC_PER_MS        ((`CLK_HZ / 1000) * `MS_TIME)

// Setting ranges and reset values
`define NEAR_AMP_MAX      31'h40000000
`define NEAR_AMP_RST      31'h40000000
`define TQ_SPD_MAX        14'h2710
`define TQ_SPD_RST        14'h2710
`define HOLD_MIN          16'h0014
`define HOLD_MAX          16'hc350
`define HOLD_RST          16'h0014
`define UV_TQ_RST         7'h32
`define UV_REL_RST        10'h064
`define MOTOR_MAX_RST     14'h1770
`define OVSPD_RST         14'h1b58

// Encodings
`define SRC_RESERVED      1'b0
`define SRC_EXTERNAL      1'b1
`define CEIL_MOTOR_MAX    1'b0
`define CEIL_OVERSPEED    1'b1
`define UV_OFF            2'h0
`define UV_HOST           2'h1
`define UV_DRIVE          2'h2

// Control-port offsets
`define OFS_NEAR_AMP      4'h0
`define OFS_TQ_SPD        4'h1
`define OFS_HOLD          4'h2
`define OFS_CFG           4'h3
`define OFS_UV_TQ         4'h4
`define OFS_UV_REL        4'h5
`define OFS_STATUS        4'h6
`define OFS_IRQ_STAT      4'h7
`define OFS_IRQ_MASK      4'h8
`define OFS_CEILINGS      4'h9

// Field positions in the configuration word
`define CFG_SRC_BIT       0
`define CFG_CEIL_BIT      1
`define CFG_UV_LSB        2
`define CFG_RST           32'h0000_0001

`endif

//--- servo_supervisor_pkg.sv
/*
  Types shared by the servo supervisory block.
  Assumes the params header is compiled alongside.
*/
package servo_supervisor_pkg;

  // Outage supervisor states
  typedef enum logic [1:0]
  {
    PWR_OK    = 2'b00,
    PWR_HOLD  = 2'b01,
    PWR_DOWN  = 2'b10
  } pwr_state_t;

  // Status outputs travelling together
  typedef struct packed
  {
    logic near;
    logic spd_limited;
    logic servo_on;
    logic servo_ready;
    logic uv_warn;
    logic cur_limit;
  } status_t;

endpackage

//--- servo_supervisor.sv
/*
  Servo supervisory logic: near-positioning flag, torque-mode speed clamp,
  momentary-outage ride-through and undervoltage warning with current limit.
  Assumes pin-level supply/alarm inputs are asynchronous; deviation and speed
  words come from control logic on MCLK; host uses the plain register port.
*/
`timescale 1ns/10ps
`include "servo_supervisor_params.svh"

module servo_supervisor
  import servo_supervisor_pkg::*;
#(
  parameter int DEV_W      = 32,
  parameter int SPD_W      = 14,
  parameter int CYC_PER_MS = `CYC_PER_MS
)
(
  input  wire logic              MCLK,
  input  wire logic              RST,
  input  wire logic [3:0]        ADDR,
  input  wire logic [31:0]       WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output      logic [31:0]       RDATA,
  input  wire logic [DEV_W-1:0]  DEVIATION,
  input  wire logic [SPD_W-1:0]  SPEED_REQ,
  input  wire logic [SPD_W-1:0]  EXTERNAL_SPEED_LIMIT_VALUE,
  input  wire logic              TORQUE_MODE,
  input  wire logic              MAIN_PWR_OK,
  input  wire logic              CTRL_PWR_OK,
  input  wire logic              BUS_LOW,
  input  wire logic              UV_ALARM,
  output      logic [SPD_W-1:0]  SPEED_CMD,
  output      logic              NEAR_FLAG,
  output      logic              SPEED_LIMITED_FLAG,
  output      logic              SERVO_ON,
  output      logic              SERVO_READY,
  output      logic              UV_WARNING,
  output      logic              CURRENT_LIMIT,
  output      logic [6:0]        TORQUE_LIMIT_PCT,
  output      logic              IRQ
);

  // Elaboration-time checks
  // The 1 ms dividers are 14 bits wide
  if (DEV_W < 32 || SPD_W < 14 || CYC_PER_MS < 1 || CYC_PER_MS > 16384)
  begin : g_chk
    $error("servo_supervisor: parameter out of range");
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [3:0] pin_s1_ff;
  logic [3:0] pin_s2_ff;
  wire  main_ok = pin_s2_ff[0];
  wire  ctrl_ok = pin_s2_ff[1];
  wire  bus_low = pin_s2_ff[2];
  wire  uv_alm  = pin_s2_ff[3];

  // Two stages; only stage two is read
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      pin_s1_ff <= 4'h3;
      pin_s2_ff <= 4'h3;
    end
    else
    begin
      pin_s1_ff <= {UV_ALARM, BUS_LOW, CTRL_PWR_OK, MAIN_PWR_OK};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // ****************************************************************
  // Settings
  // ****************************************************************
  logic [30:0]      near_amp_ff;
  logic [13:0]      tq_spd_ff;
  logic [15:0]      hold_ff;
  logic [31:0]      cfg_ff;
  logic             src_sel_ff;
  logic             ceil_sel_ff;
  logic [1:0]       uv_sel_ff;
  logic             cfg_taken_ff;
  logic             cfg_kept_ff;
  logic [6:0]       uv_tq_ff;
  logic [9:0]       uv_rel_ff;
  logic [13:0]      motor_max_ff;
  logic [13:0]      ovspd_ff;
  logic [5:0]       irq_stat_ff;
  logic [5:0]       irq_mask_ff;
  logic [31:0]      rdata_ff;
  status_t          st_ff;

  wire wr_near = WR && (ADDR == `OFS_NEAR_AMP);
  wire wr_tq   = WR && (ADDR == `OFS_TQ_SPD);
  wire wr_hold = WR && (ADDR == `OFS_HOLD);
  wire wr_cfg  = WR && (ADDR == `OFS_CFG);
  wire wr_uvt  = WR && (ADDR == `OFS_UV_TQ);
  wire wr_uvr  = WR && (ADDR == `OFS_UV_REL);
  wire wr_ist  = WR && (ADDR == `OFS_IRQ_STAT);
  wire wr_msk  = WR && (ADDR == `OFS_IRQ_MASK);
  wire wr_ceil = WR && (ADDR == `OFS_CEILINGS);

  // Clamp helper: out-of-range writes saturate rather than wrap
  function automatic logic [31:0] clampv(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
    clampv = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  wire [31:0] near_w = clampv(WDATA, 32'h0, {1'b0, `NEAR_AMP_MAX});
  wire [31:0] tq_w   = clampv(WDATA, 32'h0, {18'h0, `TQ_SPD_MAX});
  wire [31:0] hold_w = clampv(WDATA, {16'h0, `HOLD_MIN}, {16'h0, `HOLD_MAX});
  wire [31:0] uvt_w  = clampv(WDATA, 32'h0000_000a, 32'h0000_0064);
  wire [31:0] uvr_w  = clampv(WDATA, 32'h0000_000a, 32'h0000_03e8);

  // Setting registers
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      near_amp_ff  <= `NEAR_AMP_RST;
      tq_spd_ff    <= `TQ_SPD_RST;
      hold_ff      <= `HOLD_RST;
      if (cfg_kept_ff)
        cfg_ff     <= cfg_ff;
      else
        cfg_ff     <= `CFG_RST;
      uv_tq_ff     <= `UV_TQ_RST;
      uv_rel_ff    <= `UV_REL_RST;
      irq_mask_ff  <= 6'h00;
      motor_max_ff <= `MOTOR_MAX_RST;
      ovspd_ff     <= `OVSPD_RST;
    end
    else
    begin
      if (wr_near) near_amp_ff <= near_w[30:0];
      if (wr_tq)   tq_spd_ff   <= tq_w[13:0];
      if (wr_hold) hold_ff     <= hold_w[15:0];
      if (wr_cfg)  cfg_ff      <= WDATA;
      if (wr_uvt)  uv_tq_ff    <= uvt_w[6:0];
      if (wr_uvr)  uv_rel_ff   <= uvr_w[9:0];
      if (wr_msk)  irq_mask_ff <= WDATA[5:0];
      if (wr_ceil)
      begin
        motor_max_ff <= WDATA[13:0];
        ovspd_ff     <= WDATA[29:16];
      end
    end
  end

  // Stored configuration survives RST so a restart can apply it
  // Limitation: this flag has no reset, its power-up state is not guaranteed
  always_ff @(posedge MCLK)
  begin
    if (!RST && wr_cfg)
      cfg_kept_ff <= 1'b1;
  end

  // power-restart latching
  // Selections take effect once, at the first cycle after reset release
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      cfg_taken_ff <= 1'b0;
      src_sel_ff   <= `SRC_EXTERNAL;
      ceil_sel_ff  <= `CEIL_MOTOR_MAX;
      uv_sel_ff    <= `UV_OFF;
    end
    else if (!cfg_taken_ff)
    begin
      cfg_taken_ff <= 1'b1;
      src_sel_ff   <= cfg_ff[`CFG_SRC_BIT];
      ceil_sel_ff  <= cfg_ff[`CFG_CEIL_BIT];
      uv_sel_ff    <= cfg_ff[`CFG_UV_LSB +: 2];
    end
  end

  // ****************************************************************
  // Near positioning
  // ****************************************************************
  // absolute strict compare
  wire [DEV_W-1:0] dev_abs = DEVIATION[DEV_W-1] ? (~DEVIATION + 1'b1) : DEVIATION;
  wire near_now = dev_abs < {{(DEV_W-31){1'b0}}, near_amp_ff};

  // ****************************************************************
  // Speed limit
  // ****************************************************************
  function automatic logic [13:0] min14(input logic [13:0] a, input logic [13:0] b);
    min14 = (a < b) ? a : b;
  endfunction

  wire [13:0] ceiling  = (ceil_sel_ff == `CEIL_OVERSPEED) ? ovspd_ff : motor_max_ff;
  wire [13:0] int_lim  = min14(tq_spd_ff, ceiling);
  // external source takes the smaller; reserved falls back to internal
  wire [13:0] eff_lim  = (src_sel_ff == `SRC_EXTERNAL) ? min14(EXTERNAL_SPEED_LIMIT_VALUE[13:0], int_lim) : int_lim;
  wire [13:0] req14    = SPEED_REQ[13:0];
  // limiting only matters in torque mode
  wire        limiting = TORQUE_MODE && (req14 > eff_lim);
  wire [13:0] spd_out  = limiting ? eff_lim : req14;

  // ****************************************************************
  // Outage ride-through
  // ****************************************************************
  pwr_state_t  pwr_ff;
  pwr_state_t  nxt_pwr;
  logic [13:0] ms_div_ff;
  logic [15:0] ms_cnt_ff;
  wire         ms_tick = (ms_div_ff == 14'(CYC_PER_MS - 1));
  wire         hold_up = ms_tick && (ms_cnt_ff + 16'h1 >= hold_ff);

  // State decode
  always_comb
  begin
    nxt_pwr = pwr_ff;
    case (pwr_ff)
      PWR_OK:
        if (!main_ok) nxt_pwr = PWR_HOLD;
      PWR_HOLD:
        // supply loss or alarm cancels hold
        if (!ctrl_ok || uv_alm) nxt_pwr = PWR_DOWN;
        else if (hold_up) nxt_pwr = PWR_DOWN;
        else if (main_ok) nxt_pwr = PWR_OK;
      PWR_DOWN:
        if (main_ok && ctrl_ok && !uv_alm) nxt_pwr = PWR_OK;
      default:
        nxt_pwr = PWR_DOWN;
    endcase
  end

  // State register and 1 ms divider; counts only while holding
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      pwr_ff    <= PWR_DOWN;
      ms_div_ff <= 14'h0;
      ms_cnt_ff <= 16'h0;
    end
    else
    begin
      pwr_ff    <= nxt_pwr;
      ms_div_ff <= (pwr_ff != PWR_HOLD || ms_tick) ? 14'h0 : ms_div_ff + 14'h1;
      ms_cnt_ff <= (pwr_ff != PWR_HOLD) ? 16'h0 : (ms_tick ? ms_cnt_ff + 16'h1 : ms_cnt_ff);
    end
  end

  // ****************************************************************
  // Undervoltage warning
  // ****************************************************************
  logic [9:0]  rel_ms_ff;
  logic [6:0]  tq_lim_ff;
  logic [13:0] rel_div_ff;
  wire         rel_tick = (rel_div_ff == 14'(CYC_PER_MS - 1));
  wire         uv_on    = (uv_sel_ff != `UV_OFF) && bus_low;

  // drive-side torque limit and timed release
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      rel_ms_ff  <= 10'h0;
      rel_div_ff <= 14'h0;
      tq_lim_ff  <= 7'h64;
    end
    else if (uv_on && uv_sel_ff == `UV_DRIVE)
    begin
      rel_ms_ff  <= uv_rel_ff;
      rel_div_ff <= 14'h0;
      tq_lim_ff  <= uv_tq_ff;
    end
    else if (rel_ms_ff != 10'h0)
    begin
      rel_div_ff <= rel_tick ? 14'h0 : rel_div_ff + 14'h1;
      if (rel_tick)
        rel_ms_ff <= rel_ms_ff - 10'h1;
      if (rel_ms_ff == 10'h1 && rel_tick)
        tq_lim_ff <= 7'h64;
    end
    else
      tq_lim_ff <= 7'h64;
  end

  // ****************************************************************
  // Status, interrupts and read port
  // ****************************************************************
  status_t nxt_st;
  always_comb
  begin
    nxt_st.near        = near_now;
    nxt_st.spd_limited = limiting;
    nxt_st.servo_on    = (nxt_pwr != PWR_DOWN);
    nxt_st.servo_ready = (nxt_pwr != PWR_DOWN);
    nxt_st.uv_warn     = uv_on;
    nxt_st.cur_limit   = uv_on || (rel_ms_ff != 10'h0);
  end

  // Rising edges of each status bit are the events
  wire [5:0] ev   = nxt_st & ~st_ff;
  wire [5:0] rsel = {2'h0, ADDR};

  // Status outputs, sticky bits (set beats clear) and read data
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      st_ff       <= '0;
      irq_stat_ff <= 6'h00;
      rdata_ff    <= 32'h0;
      SPEED_CMD   <= '0;
    end
    else
    begin
      st_ff       <= nxt_st;
      SPEED_CMD   <= SPD_W'(spd_out);
      irq_stat_ff <= (irq_stat_ff & ~(wr_ist ? WDATA[5:0] : 6'h00)) | ev;
      if (RD)
        case (rsel)
          6'(`OFS_NEAR_AMP): rdata_ff <= {1'b0, near_amp_ff};
          6'(`OFS_TQ_SPD):   rdata_ff <= {18'h0, tq_spd_ff};
          6'(`OFS_HOLD):     rdata_ff <= {16'h0, hold_ff};
          6'(`OFS_CFG):      rdata_ff <= cfg_ff;
          6'(`OFS_UV_TQ):    rdata_ff <= {25'h0, uv_tq_ff};
          6'(`OFS_UV_REL):   rdata_ff <= {22'h0, uv_rel_ff};
          6'(`OFS_STATUS):   rdata_ff <= {24'h0, pwr_ff, st_ff};
          6'(`OFS_IRQ_STAT): rdata_ff <= {26'h0, irq_stat_ff};
          6'(`OFS_IRQ_MASK): rdata_ff <= {26'h0, irq_mask_ff};
          6'(`OFS_CEILINGS): rdata_ff <= {2'h0, ovspd_ff, 2'h0, motor_max_ff};
          default:           rdata_ff <= 32'h0;
        endcase
      else
        rdata_ff <= 32'h0;
    end
  end

  // Output wiring
  assign RDATA              = rdata_ff;
  assign NEAR_FLAG          = st_ff.near;
  assign SPEED_LIMITED_FLAG = st_ff.spd_limited;
  assign SERVO_ON           = st_ff.servo_on;
  assign SERVO_READY        = st_ff.servo_ready;
  assign UV_WARNING         = st_ff.uv_warn;
  assign CURRENT_LIMIT      = st_ff.cur_limit;
  assign TORQUE_LIMIT_PCT   = tq_lim_ff;
  assign IRQ                = |(irq_stat_ff & irq_mask_ff);

endmodule

//--- servo_supervisor_props.sv
/*
  Port checker for servo_supervisor.
  Assumes settings stay in range and the ceilings word is never written.
*/
`timescale 1ns/10ps
module servo_supervisor_props
#(
  parameter int DEV_W      = 32,
  parameter int SPD_W      = 14,
  parameter int CYC_PER_MS = 10000
)
(
  input wire logic             MCLK,
  input wire logic             RST,
  input wire logic [3:0]       ADDR,
  input wire logic [31:0]      WDATA,
  input wire logic             WR,
  input wire logic [DEV_W-1:0] DEVIATION,
  input wire logic [SPD_W-1:0] SPEED_REQ,
  input wire logic [SPD_W-1:0] EXTERNAL_SPEED_LIMIT_VALUE,
  input wire logic             TORQUE_MODE,
  input wire logic             MAIN_PWR_OK,
  input wire logic             CTRL_PWR_OK,
  input wire logic             BUS_LOW,
  input wire logic             UV_ALARM,
  input wire logic [SPD_W-1:0] SPEED_CMD,
  input wire logic             NEAR_FLAG,
  input wire logic             SPEED_LIMITED_FLAG,
  input wire logic             SERVO_ON,
  input wire logic             SERVO_READY,
  input wire logic             UV_WARNING,
  input wire logic             CURRENT_LIMIT,
  input wire logic [6:0]       TORQUE_LIMIT_PCT
);
  // ****************************************
  // Helpers
  // ****************************************
  // One ms tick of slack; the tick phase is locked to the start of each hold
  localparam int HOLD_CYC = 19 * CYC_PER_MS;
  logic [31:0]      amp_ff;
  logic [31:0]      lo_cnt_ff;
  wire  logic [DEV_W-1:0] mag = DEVIATION[DEV_W-1] ? -DEVIATION : DEVIATION;
  // Shadow of the near amplitude and length of the current outage
  always_ff @(posedge MCLK)
  begin
    amp_ff    <= RST ? 32'h40000000 : (WR && ADDR == 4'h0) ? WDATA : amp_ff;
    lo_cnt_ff <= MAIN_PWR_OK ? 32'h0 : lo_cnt_ff + 32'h1;
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  chk_near_cmp: assert property (!$past(RST) |-> NEAR_FLAG == ($past(mag) < $past(amp_ff)))
    else $error("near flag wrong");
  chk_lim_flag: assert property (!$past(RST) && $past(TORQUE_MODE) && SPEED_CMD < $past(SPEED_REQ) |-> SPEED_LIMITED_FLAG)
    else $error("limited flag missing");
  chk_ext_cap: assert property (!$past(RST) && $past(TORQUE_MODE) |-> SPEED_CMD <= $past(EXTERNAL_SPEED_LIMIT_VALUE))
    else $error("speed above external limit");
  chk_ready_off: assert property ($fell(SERVO_ON) |-> !SERVO_READY)
    else $error("ready kept after servo off");
  chk_hold_min: assert property ($fell(SERVO_ON) && CTRL_PWR_OK && $past(CTRL_PWR_OK, 4) && !UV_ALARM
    && !$past(UV_ALARM, 4) |-> lo_cnt_ff >= HOLD_CYC)
    else $error("servo dropped inside hold time");
  chk_recover: assert property ($rose(MAIN_PWR_OK) ##0 (MAIN_PWR_OK && CTRL_PWR_OK && !UV_ALARM)[*6] |-> SERVO_ON)
    else $error("servo not back after main return");
  chk_ctrl_loss: assert property ((!MAIN_PWR_OK && !CTRL_PWR_OK)[*8] |-> !SERVO_ON)
    else $error("hold kept on control loss");
  chk_uv_alarm: assert property ((!MAIN_PWR_OK && UV_ALARM)[*8] |-> !SERVO_ON)
    else $error("hold kept on undervoltage alarm");
  // warning follows the pin three cycles later
  chk_uv_warn: assert property (UV_WARNING |-> CURRENT_LIMIT && $past(BUS_LOW, 3))
    else $error("warning without low bus or current limit");
  chk_tq_range: assert property (TORQUE_LIMIT_PCT >= 7'h0a && TORQUE_LIMIT_PCT <= 7'h64)
    else $error("torque limit out of range");
endmodule

bind servo_supervisor servo_supervisor_props #(.DEV_W(DEV_W), .SPD_W(SPD_W), .CYC_PER_MS(CYC_PER_MS)) u_props (
  .MCLK(MCLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .DEVIATION(DEVIATION),
  .SPEED_REQ(SPEED_REQ), .EXTERNAL_SPEED_LIMIT_VALUE(EXTERNAL_SPEED_LIMIT_VALUE),
  .TORQUE_MODE(TORQUE_MODE), .MAIN_PWR_OK(MAIN_PWR_OK), .CTRL_PWR_OK(CTRL_PWR_OK),
  .BUS_LOW(BUS_LOW), .UV_ALARM(UV_ALARM), .SPEED_CMD(SPEED_CMD), .NEAR_FLAG(NEAR_FLAG),
  .SPEED_LIMITED_FLAG(SPEED_LIMITED_FLAG), .SERVO_ON(SERVO_ON), .SERVO_READY(SERVO_READY),
  .UV_WARNING(UV_WARNING), .CURRENT_LIMIT(CURRENT_LIMIT), .TORQUE_LIMIT_PCT(TORQUE_LIMIT_PCT));

//--- host_ctl_model.sv
/*
  Host motion controller model: settings it programs, external speed limit.
  Assumes the bench names the limit it wants.
*/
`timescale 1ns/10ps
module host_ctl_model
#(
  parameter int COMP_AMP = 10
)
(
  input  wire logic        MCLK,
  input  wire logic [13:0] want_lim,
  output      logic [13:0] ext_lim,
  output      logic [31:0] near_amp,
  output      logic [31:0] cfg_word
);
  assign near_amp = 32'(COMP_AMP * 10);
  assign cfg_word = 32'h0000000b;
  // Limit moves only after an edge, as a real host output
  always_ff @(posedge MCLK)
  begin
    ext_lim <= want_lim;
  end
endmodule

//--- tb_servo_supervisor.sv
/*
  Self-checking bench for servo_supervisor.
  Assumes CYC_PER_MS of 4, so one ms is four clocks.
*/
`timescale 1ns/10ps
module tb_servo_supervisor;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] dev = 32'h0;
  logic [13:0] req = 14'h0;
  logic [13:0] want = 14'h0;
  logic        tmode = 1'b0;
  logic        main_ok = 1'b1;
  logic        ctrl_ok = 1'b1;
  logic        bus_low = 1'b0;
  logic        uv_alm = 1'b0;
  wire  logic [31:0] rdata;
  wire  logic [31:0] near_amp;
  wire  logic [31:0] cfg_word;
  wire  logic [13:0] ext;
  wire  logic [13:0] spd_cmd;
  wire  logic        near;
  wire  logic        lim;
  wire  logic        on;
  wire  logic        rdy;
  wire  logic        uvw;
  wire  logic        curl;
  wire  logic [6:0]  pct;
  wire  logic        irq;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          cyc = 0;
  // ****************************************
  // Design, host and clock
  // ****************************************
  servo_supervisor #(.CYC_PER_MS(4)) u_dut (.MCLK(mclk), .RST(rst), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .DEVIATION(dev), .SPEED_REQ(req), .EXTERNAL_SPEED_LIMIT_VALUE(ext),
    .TORQUE_MODE(tmode), .MAIN_PWR_OK(main_ok), .CTRL_PWR_OK(ctrl_ok), .BUS_LOW(bus_low),
    .UV_ALARM(uv_alm), .SPEED_CMD(spd_cmd), .NEAR_FLAG(near), .SPEED_LIMITED_FLAG(lim), .SERVO_ON(on),
    .SERVO_READY(rdy), .UV_WARNING(uvw), .CURRENT_LIMIT(curl), .TORQUE_LIMIT_PCT(pct), .IRQ(irq));
  host_ctl_model u_host (.MCLK(mclk), .want_lim(want), .ext_lim(ext), .near_amp(near_amp),
    .cfg_word(cfg_word));
  always #50 mclk = ~mclk;
  // Hang guard, well above the roughly 900 cycles needed
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      stop_test();
    end
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  endtask
  // Settle one ns past the edge so that flags are read stable
  task automatic w(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr_reg(logic [3:0] a, logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [3:0] a, logic [31:0] exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk("rdata", exp, rdata);
  endtask
  task automatic sp(logic [13:0] l, logic [13:0] r, logic [13:0] c, logic f);
    want <= l;
    req <= r;
    w(4);
    chk("speed_cmd", 32'(c), 32'(spd_cmd));
    chk("limited", 32'(f), 32'(lim));
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_near();
    logic [31:0] dvs [4] = '{32'h63, 32'h64, 32'hffffff9d, 32'hffffff9c};
    logic        exs [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    wr_reg(4'h0, near_amp);
    for (int i = 0; i < 4; i++)
    begin
      dev <= dvs[i];
      w(3);
      chk("near", 32'(exs[i]), 32'(near));
    end
  endtask
  task automatic t_speed();
    tmode <= 1'b1;
    sp(14'hbb8, 14'h1388, 14'hbb8, 1'b1);
    sp(14'hbb8, 14'h7d0, 14'h7d0, 1'b0);
    sp(14'h2328, 14'h2328, 14'h1770, 1'b1);
    wr_reg(4'h1, 32'hfa0);
    sp(14'h2328, 14'h2328, 14'hfa0, 1'b1);
    wr_reg(4'h1, 32'h2710);
    // New selections only count after a restart
    wr_reg(4'h3, cfg_word);
    @(posedge mclk);
    rst <= 1'b1;
    w(2);
    rst <= 1'b0;
    w(8);
    sp(14'h2328, 14'h2328, 14'h1b58, 1'b1);
    tmode <= 1'b0;
    sp(14'h2328, 14'h2328, 14'h2328, 1'b0);
  endtask
  task automatic t_outage();
    main_ok <= 1'b0;
    w(40);
    chk("on_short", 1, on);
    main_ok <= 1'b1;
    w(8);
    main_ok <= 1'b0;
    w(150);
    chk("on_long", 0, on);
    chk("ready_long", 0, rdy);
    main_ok <= 1'b1;
    w(8);
    chk("on_back", 1, on);
    main_ok <= 1'b0;
    w(10);
    ctrl_ok <= 1'b0;
    w(10);
    chk("on_ctrl", 0, on);
    ctrl_ok <= 1'b1;
    main_ok <= 1'b1;
    w(8);
    // Alarm raised inside a fresh hold window, well before it expires
    main_ok <= 1'b0;
    w(6);
    uv_alm <= 1'b1;
    w(10);
    chk("on_alarm", 0, on);
    uv_alm <= 1'b0;
    w(4);
    main_ok <= 1'b1;
    w(8);
  endtask
  task automatic t_uv();
    wr_reg(4'h7, 32'h3f);
    wr_reg(4'h8, 32'h0);
    bus_low <= 1'b1;
    w(6);
    chk("uv_warn", 1, uvw);
    chk("cur_limit", 1, curl);
    chk("tq_pct", 32'h32, 32'(pct));
    chk("irq_masked", 0, irq);
    wr_reg(4'h8, 32'h2);
    w(1);
    chk("irq_on", 1, irq);
    rd_reg(4'h8, 32'h2);
    bus_low <= 1'b0;
    w(300);
    chk("tq_held", 32'h32, 32'(pct));
    w(200);
    chk("tq_free", 32'h64, 32'(pct));
    chk("uv_clear", 0, uvw);
    wr_reg(4'h7, 32'h2);
    w(1);
    chk("irq_clear", 0, irq);
    rd_reg(4'h6, 32'h2c);
    rd_reg(4'hf, 32'h0);
  endtask
  task automatic stop_test();
    if (n_mismatch == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    w(8);
    t_near();
    t_speed();
    t_outage();
    t_uv();
    stop_test();
  end
endmodule
